// ==== rtl/sram_ctl_pkg.sv ====
// package for the asynchronous static memory controller
// assumes a single 25 MHz system clock
package sram_ctl_pkg;
   localparam int ADDR_W        = 17;
   localparam int DATA_W        = 24;
   localparam int CLK_PERIOD_PS = 40000;
   // device timing in picoseconds, slower grade
   localparam int T_WRITE_PULSE_PS = 10000;
   localparam int T_DATA_SETUP_PS  = 6000;
   localparam int T_ADDR_SETUP_PS  = 8000;
   localparam int T_READ_ACCESS_PS = 10000;
   localparam int T_FLOAT_PS       = 5000;
   localparam int T_DATA_HOLD_PS   = 0;
   // least times round up, never below one cycle
   localparam int WR_CYCLES =
      (T_WRITE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETUP_CYCLES =
      (T_ADDR_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RD_CYCLES =
      ((T_READ_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + 1;
   localparam int TURN_CYCLES =
      (T_FLOAT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 4;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_WRITE = 3'b011,
      ST_READ  = 3'b010,
      ST_TURN  = 3'b110
   } ctl_state_t;
endpackage : sram_ctl_pkg

// ==== rtl/cycle_timer.sv ====
// down-counter that flags when a loaded wait has run out
// assumes synchronous active-high reset
`timescale 1ns/1ps
module cycle_timer #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              done
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // done must not look at load: the owner decides load from done
   assign done = (cnt_r == '0);
endmodule : cycle_timer

// ==== rtl/sram_ctl.sv ====
// host controller driving an asynchronous 128K x 24 static memory
// assumes memory pins are synchronous to ref_clk; one access at a time
`timescale 1ns/1ps

// Operation
// - write only while low select low, high select high, strobe low.
// - all three qualifiers valid before write starts; any one may end it.
// - data setup and hold timed against the edge that ends the write.
// - write data stable 5 ns (fast) or 6 ns (slow) before write end.
// - write data may change at the write-ending edge; hold is 0 ns.
// - address may change at the write-ending edge; hold is 0 ns.
// - write strobe stays high throughout any read access.
// - address valid no later than both selects becoming active.
// - low select driven low selects; high deselects and floats data.
// - high select driven high selects; low deselects and floats data.
module sram_ctl
   import sram_ctl_pkg::*;
#(
   parameter int AW = sram_ctl_pkg::ADDR_W,
   parameter int DW = sram_ctl_pkg::DATA_W
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          sys_rst,
   // user request
   input  wire logic          req_valid,
   input  wire logic          req_write,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [DW-1:0] req_wdata,
   output logic               req_ready,
   // user read answer
   output logic               rsp_valid,
   output logic [DW-1:0]      rsp_rdata,
   // memory pins
   output logic [AW-1:0]      mem_addr,
   output logic               select_active_low_n,
   output logic               select_active_high,
   output logic               out_enable_n,
   output logic               write_strobe_n,
   input  wire logic [DW-1:0] mem_data_in,
   output logic [DW-1:0]      mem_data_out,
   output logic               mem_data_oe
);
   import sram_ctl_pkg::*;

   ctl_state_t       state_r;
   ctl_state_t       state_nxt;
   logic             wr_r;
   logic             tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic             tmr_done;
   logic             take;
   logic             sel_nxt;

   cycle_timer #(.W(CNT_W)) u_timer (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   assign req_ready = (state_r == ST_IDLE);
   assign take      = req_valid && req_ready;
   // selects active in the write or read phase of the coming cycle
   assign sel_nxt   = (state_nxt == ST_WRITE) || (state_nxt == ST_READ);

   // next state and timer loads
   always_comb begin
      state_nxt = state_r;
      tmr_load  = 1'b0;
      tmr_val   = '0;
      unique case (state_r)
         ST_IDLE: begin
            if (req_valid) begin
               // address settles one phase before selects
               state_nxt = ST_SETUP;
               tmr_load  = 1'b1;
               tmr_val   = CNT_W'(SETUP_CYCLES - 1);
            end
         end
         ST_SETUP: begin
            // phase chosen by the kind of access taken
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (wr_r) begin
                  state_nxt = ST_WRITE;
                  tmr_val   = CNT_W'(WR_CYCLES - 1);
               end else begin
                  state_nxt = ST_READ;
                  tmr_val   = CNT_W'(RD_CYCLES - 1);
               end
            end
         end
         ST_WRITE: begin
            // selects and strobe rise at one edge
            if (tmr_done) begin
               state_nxt = ST_TURN;
               tmr_load  = 1'b1;
               tmr_val   = CNT_W'(TURN_CYCLES - 1);
            end
         end
         ST_READ: begin
            // data sampled on the last edge of this phase
            if (tmr_done) begin
               state_nxt = ST_TURN;
               tmr_load  = 1'b1;
               tmr_val   = CNT_W'(TURN_CYCLES - 1);
            end
         end
         ST_TURN: begin
            // memory released the bus before next access
            if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // access kind, held until the access ends
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_r <= 1'b0;
      end else if (take) begin
         wr_r <= req_write;
      end
   end

   // address held unchanged past the write-ending edge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mem_addr <= '0;
      end else if (take) begin
         mem_addr <= req_addr;
      end
   end

   // write data set up two full cycles before the write ends
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mem_data_out <= '0;
      end else if (take) begin
         mem_data_out <= req_wdata;
      end
   end

   // low select: high while idle, so the memory floats its pins
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         select_active_low_n <= 1'b1;
      end else begin
         select_active_low_n <= !sel_nxt;
      end
   end

   // high select moves with the low select
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         select_active_high <= 1'b0;
      end else begin
         select_active_high <= sel_nxt;
      end
   end

   // strobe: falls with selects and rises with them, ending the write;
   // data stays valid past that edge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         write_strobe_n <= 1'b1;
      end else begin
         write_strobe_n <= !(state_nxt == ST_WRITE);
      end
   end

   // data bus drive from the take through one cycle past the write end;
   // kind taken from the request, as wr_r still holds the last one's
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mem_data_oe <= 1'b0;
      end else if (take) begin
         mem_data_oe <= req_write;
      end else begin
         mem_data_oe <= wr_r && (state_nxt == ST_WRITE ||
                                 state_r == ST_WRITE);
      end
   end

   // output enable only during the read phase
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         out_enable_n <= 1'b1;
      end else begin
         out_enable_n <= !(state_nxt == ST_READ);
      end
   end

   // read data sampled at end of read phase
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (state_r == ST_READ && tmr_done) begin
            rsp_valid <= 1'b1;
            rsp_rdata <= mem_data_in;
         end
      end
   end
endmodule : sram_ctl

// ==== dv/sram_ctl_sva.sv ====
// pin checker for the static memory controller
// assumes bind onto sram_ctl; one clock domain
`timescale 1ns/1ps
module sram_ctl_sva
   import sram_ctl_pkg::*;
(
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              sys_rst,
   // user side
   input wire logic              req_valid,
   input wire logic              req_write,
   input wire logic              req_ready,
   input wire logic              rsp_valid,
   // memory pins
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [DATA_W-1:0] mem_data_out,
   input wire logic              select_active_low_n,
   input wire logic              select_active_high,
   input wire logic              out_enable_n,
   input wire logic              write_strobe_n,
   input wire logic              mem_data_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire sel  = !select_active_low_n && select_active_high;
   wire take = req_valid && req_ready;
   sequence wr_s;
      mem_data_oe && !sel ##1 sel && !write_strobe_n
      ##1 !sel && write_strobe_n && mem_data_oe ##1 !mem_data_oe;
   endsequence
   sequence rd_s;
      !sel ##1 (sel && !out_enable_n && !mem_data_oe) [*2] ##1 !sel;
   endsequence
   wr_walk_a: assert property (take && req_write |=> wr_s)
      else $error("write pin order wrong");
   rd_walk_a: assert property (take && !req_write |=> rd_s)
      else $error("read pin order wrong");
   rsp_time_a: assert property (
      take && !req_write |-> ##4 rsp_valid)
      else $error("read answer late");
   wr_qual_a: assert property (
      !write_strobe_n |-> sel && out_enable_n)
      else $error("strobe low outside select");
   rd_strobe_a: assert property (
      !out_enable_n |-> write_strobe_n)
      else $error("strobe low in read");
   sel_pair_a: assert property (
      $fell(select_active_low_n) |-> $rose(select_active_high))
      else $error("selects apart");
   data_setup_a: assert property (
      !write_strobe_n |-> $stable(mem_data_out) && $stable(mem_addr))
      else $error("data moved in write");
   data_hold_a: assert property (
      $rose(write_strobe_n) |-> mem_data_oe && $stable(mem_data_out)
         && $stable(mem_addr))
      else $error("data not held");
endmodule : sram_ctl_sva

// ==== dv/sram_model.sv ====
// behavioural asynchronous 128K x 24 static memory
// assumes bus level resolved by the bench
`timescale 1ns/1ps
module sram_model (
   input wire logic [16:0] addr,
   input wire logic        cs_n, cs, oe_n, we_n,
   input wire logic [23:0] din,
   output logic [23:0]     dout
);
   logic [23:0] mem [0:131071];
   logic [23:0] acc;
   logic [23:0] last = 24'h000000;
   logic        drive;
   wire wr = !cs_n && cs && !we_n;
   wire rd = !cs_n && cs && !oe_n && we_n;
   always @(negedge wr) mem[addr] = din;
   assign #10 acc = mem[addr];
   assign #2 drive = rd;
   always @(negedge drive) last = acc;
   // released bus shows inverse of last word
   assign dout = drive ? acc : ~last;
endmodule : sram_model

// ==== dv/sram_ctl_tb_top.sv ====
// testbench for the static memory controller
// assumes sram_model on the pins, checker bound below
`timescale 1ns/1ps
module sram_ctl_tb_top;
   import sram_ctl_pkg::*;
   logic ref_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0;
   logic req_ready, rsp_valid, mem_data_oe, write_strobe_n, out_enable_n;
   logic select_active_low_n, select_active_high;
   logic [ADDR_W-1:0] req_addr = '0, mem_addr;
   logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, mem_data_out, mem_data_in, q;
   logic [DATA_W-1:0] mdin;
   logic [ADDR_W-1:0] tbl [3] = '{17'h00000, 17'h1FFFF, 17'h0AAAA};
   int err_count = 0, cmp_count = 0;
   always #20 ref_clk = ~ref_clk;
   assign mem_data_in = mem_data_oe ? mem_data_out : mdin;
   sram_ctl sram_ctl_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
      .select_active_low_n(select_active_low_n),
      .select_active_high(select_active_high),
      .out_enable_n(out_enable_n), .write_strobe_n(write_strobe_n),
      .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
      .mem_data_oe(mem_data_oe));
   sram_model sram_model_i (.addr(mem_addr), .cs_n(select_active_low_n),
      .cs(select_active_high), .oe_n(out_enable_n), .we_n(write_strobe_n),
      .din(mem_data_in), .dout(mdin));
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task tally(input bit ok, input string m);
      cmp_count++;
      if (!ok) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : tally
   task chk_data(input logic [DATA_W-1:0] g, e);
      tally(g === e, "read data");
   endtask : chk_data
   task chk_pins(input logic [4:0] e);
      tally({select_active_low_n, select_active_high, out_enable_n,
             write_strobe_n, mem_data_oe} === e, "idle pins");
   endtask : chk_pins
   task step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   task access(input logic w, input logic [ADDR_W-1:0] a,
               input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      req_valid = 1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      step(1);
      req_valid = 0;
      step(1);
      while (!w && rsp_valid !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      tally(n < 20, "handshake");
      q = rsp_rdata;
   endtask : access
   task t_reset;
      step(1);
      chk_pins(5'b10110);
      $display("test reset done");
   endtask : t_reset
   task t_bounds;
      for (int i = 0; i < 3; i++) access(1, tbl[i], {7'h5A, tbl[i]});
      for (int i = 0; i < 3; i++) begin
         access(0, tbl[i], '0);
         chk_data(q, {7'h5A, tbl[i]});
      end
      $display("test bounds done");
   endtask : t_bounds
   task t_b2b;
      access(1, 17'h00010, 24'hA5A5A5);
      access(1, 17'h00010, 24'h5A5A5A);
      access(1, 17'h00011, 24'hFFFFFF);
      access(0, 17'h00010, '0);
      chk_data(q, 24'h5A5A5A);
      access(0, 17'h00011, '0);
      chk_data(q, 24'hFFFFFF);
      $display("test back to back done");
   endtask : t_b2b
   task t_rst_mid;
      // wait for idle so the write is taken, then reset it in setup
      while (req_ready !== 1'b1) begin
         step(1);
      end
      req_valid = 1;
      req_write = 1;
      req_addr = 17'h00000;
      req_wdata = 24'h000000;
      step(1);
      req_valid = 0;
      sys_rst = 1;
      step(1);
      sys_rst = 0;
      chk_pins(5'b10110);
      access(0, 17'h00000, '0);
      chk_data(q, 24'hB40000);
      $display("test mid reset done");
   endtask : t_rst_mid
   initial begin
      step(2);
      sys_rst = 0;
      t_reset;
      t_bounds;
      t_b2b;
      t_rst_mid;
      test_done;
   end
   initial begin
      #100000;
      tally(0, "timeout");
      test_done;
   end
endmodule : sram_ctl_tb_top
bind sram_ctl sram_ctl_sva sram_ctl_sva_i (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
   .req_ready(req_ready), .rsp_valid(rsp_valid), .mem_addr(mem_addr),
   .mem_data_out(mem_data_out),
   .select_active_low_n(select_active_low_n),
   .select_active_high(select_active_high), .out_enable_n(out_enable_n),
   .write_strobe_n(write_strobe_n), .mem_data_oe(mem_data_oe));
